//--- design/timer8_pkg.sv
// timer8_pkg: register map, field positions and shared types of the 8-bit timer
// assumes: one aclk domain at 100 MHz, AXI4-Lite register access
package timer8_pkg;
   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [4:0] ADDR_CTRL_A = 5'h00;
   localparam logic [4:0] ADDR_CTRL_B = 5'h04;
   localparam logic [4:0] ADDR_COUNT  = 5'h08;
   localparam logic [4:0] ADDR_CMP_A  = 5'h0c;
   localparam logic [4:0] ADDR_CMP_B  = 5'h10;
   localparam logic [4:0] ADDR_MASK   = 5'h14;
   localparam logic [4:0] ADDR_FLAGS  = 5'h18;
   localparam logic [4:0] ADDR_IRQ    = 5'h1c;
   // ------------------------------------------------------------
   // field layouts and constants
   // ------------------------------------------------------------
   localparam logic [7:0] CTRL_A_MASK  = 8'hf3;
   localparam logic [7:0] CTRL_B_MASK  = 8'h0f;
   localparam logic [7:0] IRQ3_MASK    = 8'h07;
   localparam logic [7:0] CNT_MAX      = 8'hff;
   localparam logic [7:0] CNT_BOTTOM   = 8'h00;
   localparam logic [7:0] RESET_VAL    = 8'h00;
   localparam int         BIT_FORCE_A  = 7;
   localparam int         BIT_FORCE_B  = 6;
   localparam int         BIT_WGM_UP   = 3;
   localparam int         BIT_FLAG_B   = 2;
   localparam int         BIT_FLAG_A   = 1;
   localparam int         BIT_FLAG_OVF = 0;
   localparam logic [1:0] RESP_OKAY    = 2'b00;
   localparam logic [1:0] RESP_SLVERR  = 2'b10;
   localparam logic [9:0] DIV_8        = 10'h007;
   localparam logic [9:0] DIV_64       = 10'h03f;
   localparam logic [9:0] DIV_256      = 10'h0ff;
   localparam logic [9:0] DIV_1024     = 10'h3ff;
   // output-mode field values
   localparam logic [1:0] OM_OFF = 2'b00;
   localparam logic [1:0] OM_TGL = 2'b01;
   localparam logic [1:0] OM_CLR = 2'b10;
   localparam logic [1:0] OM_SET = 2'b11;
   // clock select values
   localparam logic [2:0] CS_STOP = 3'h0;
   localparam logic [2:0] CS_IO   = 3'h1;
   localparam logic [2:0] CS_D8   = 3'h2;
   localparam logic [2:0] CS_D64  = 3'h3;
   localparam logic [2:0] CS_D256 = 3'h4;
   localparam logic [2:0] CS_D1K  = 3'h5;
   localparam logic [2:0] CS_FALL = 3'h6;
   localparam logic [2:0] CS_RISE = 3'h7;
   // waveform mode values
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_PC_FF  = 3'h1;
   localparam logic [2:0] WM_CTC    = 3'h2;
   localparam logic [2:0] WM_FAST_F = 3'h3;
   localparam logic [2:0] WM_PC_A   = 3'h5;
   localparam logic [2:0] WM_FAST_A = 3'h7;

   typedef struct packed {
      logic [1:0] out_mode_chan_a;
      logic [1:0] out_mode_chan_b;
      logic [1:0] waveform_mode_sel;
      logic       waveform_mode_upper;
      logic [2:0] timer_clk_sel;
   } ctrl_s;

   typedef struct packed {
      logic wave_out_chan_a;
      logic wave_out_chan_b;
      logic drive_en_chan_a;
      logic drive_en_chan_b;
   } pins_s;
endpackage

//--- design/timer8.sv
// timer8: 8-bit timer/counter with two compare channels behind an AXI4-Lite slave
// assumes: ext_count_pin is asynchronous; pin direction bits and global irq enable
// come from neighbouring port and cpu logic
`timescale 1ns/1ps
`default_nettype none
module timer8 (
   input  wire  logic                 aclk,
   input  wire  logic                 aresetn,
   input  wire  logic [4:0]           s_axi_awaddr,
   input  wire  logic                 s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire  logic [31:0]          s_axi_wdata,
   input  wire  logic [3:0]           s_axi_wstrb,
   input  wire  logic                 s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire  logic                 s_axi_bready,
   input  wire  logic [4:0]           s_axi_araddr,
   input  wire  logic                 s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire  logic                 s_axi_rready,
   input  wire  logic                 ext_count_pin,
   input  wire  logic                 dir_chan_a,
   input  wire  logic                 dir_chan_b,
   input  wire  logic                 cpu_status_word_ie,
   input  wire  logic [2:0]           vector_ack,
   output timer8_pkg::pins_s          pins,
   output logic [2:0]                 irq_req
);
   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   timer8_pkg::ctrl_s ctrl_r;
   logic [7:0]        timer_count_r;
   logic [7:0]        cmp_a_buf_r, cmp_b_buf_r;
   logic [7:0]        cmp_a_r, cmp_b_r;
   logic [2:0]        timer_irq_mask_r;
   logic [2:0]        timer_irq_flags_r;
   logic              dir_down_r;
   logic              block_r;
   logic              oc_a_r, oc_b_r;
   logic [2:0]        ext_sync_r;
   logic              ext_prev_r;
   logic [9:0]        presc_r;

   // ------------------------------------------------------------
   // bus slave: address and data taken together, one cycle answer
   // ------------------------------------------------------------
   logic        wr_go, rd_go, wr_ok;
   logic [7:0]  wd;
   assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign rd_go = s_axi_arvalid && !s_axi_rvalid;
   assign wd    = s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
   assign wr_ok = wr_go && s_axi_wstrb[0];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= timer8_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= wr_go;
         s_axi_wready  <= wr_go;
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr > timer8_pkg::ADDR_FLAGS)
                            ? timer8_pkg::RESP_SLVERR : timer8_pkg::RESP_OKAY;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic [7:0] rd_byte;
   always_comb begin
      unique case (s_axi_araddr)
         timer8_pkg::ADDR_CTRL_A: rd_byte = {ctrl_r.out_mode_chan_a, ctrl_r.out_mode_chan_b,
                                              2'b00, ctrl_r.waveform_mode_sel};
         timer8_pkg::ADDR_CTRL_B: rd_byte = {4'h0, ctrl_r.waveform_mode_upper,
                                              ctrl_r.timer_clk_sel};
         timer8_pkg::ADDR_COUNT:  rd_byte = timer_count_r;
         timer8_pkg::ADDR_CMP_A:  rd_byte = cmp_a_buf_r;
         timer8_pkg::ADDR_CMP_B:  rd_byte = cmp_b_buf_r;
         timer8_pkg::ADDR_MASK:   rd_byte = {5'h00, timer_irq_mask_r};
         timer8_pkg::ADDR_FLAGS:  rd_byte = {5'h00, timer_irq_flags_r};
         default:                 rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= timer8_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= rd_go;
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= (s_axi_araddr > timer8_pkg::ADDR_FLAGS)
                            ? timer8_pkg::RESP_SLVERR : timer8_pkg::RESP_OKAY;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   logic wr_ctrl_a, wr_ctrl_b, wr_cnt, wr_ca, wr_cb, wr_mask, wr_flags;
   assign wr_ctrl_a = wr_ok && s_axi_awaddr == timer8_pkg::ADDR_CTRL_A;
   assign wr_ctrl_b = wr_ok && s_axi_awaddr == timer8_pkg::ADDR_CTRL_B;
   assign wr_cnt    = wr_ok && s_axi_awaddr == timer8_pkg::ADDR_COUNT;
   assign wr_ca     = wr_ok && s_axi_awaddr == timer8_pkg::ADDR_CMP_A;
   assign wr_cb     = wr_ok && s_axi_awaddr == timer8_pkg::ADDR_CMP_B;
   assign wr_mask   = wr_ok && s_axi_awaddr == timer8_pkg::ADDR_MASK;
   assign wr_flags  = wr_ok && s_axi_awaddr == timer8_pkg::ADDR_FLAGS;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_r           <= '0;
         timer_irq_mask_r <= 3'b000;
      end else begin
         if (wr_ctrl_a) begin
            ctrl_r.out_mode_chan_a   <= wd[7:6];
            ctrl_r.out_mode_chan_b   <= wd[5:4];
            ctrl_r.waveform_mode_sel <= wd[1:0];
         end
         if (wr_ctrl_b) begin
            ctrl_r.waveform_mode_upper <= wd[timer8_pkg::BIT_WGM_UP];
            ctrl_r.timer_clk_sel       <= wd[2:0];
         end
         if (wr_mask)
            timer_irq_mask_r <= wd[2:0];
      end
   end

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   logic [2:0] wmode;
   logic       is_pc, is_fast, is_pwm;
   logic [7:0] top;
   assign wmode = {ctrl_r.waveform_mode_upper, ctrl_r.waveform_mode_sel};
   assign is_pc   = wmode == timer8_pkg::WM_PC_FF  || wmode == timer8_pkg::WM_PC_A;
   assign is_fast = wmode == timer8_pkg::WM_FAST_F || wmode == timer8_pkg::WM_FAST_A;
   assign is_pwm  = is_pc || is_fast;
   assign top = (wmode == timer8_pkg::WM_CTC || wmode == timer8_pkg::WM_PC_A ||
                 wmode == timer8_pkg::WM_FAST_A) ? cmp_a_r : timer8_pkg::CNT_MAX;

   // ------------------------------------------------------------
   // clock select and external pin
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_sync_r <= 3'b000;
         ext_prev_r <= 1'b0;
         presc_r    <= 10'h000;
      end else begin
         ext_sync_r <= {ext_sync_r[1:0], ext_count_pin};
         if (ext_sync_r[2] == ext_sync_r[1])
            ext_prev_r <= ext_sync_r[2];
         presc_r <= presc_r + 10'h001;
      end
   end

   logic ext_ok, ext_rise, ext_fall, tick;
   assign ext_ok   = ext_sync_r[2] == ext_sync_r[1];
   assign ext_rise = ext_ok && ext_sync_r[2] && !ext_prev_r;
   assign ext_fall = ext_ok && !ext_sync_r[2] && ext_prev_r;
   always_comb begin
      unique case (ctrl_r.timer_clk_sel)
         timer8_pkg::CS_STOP: tick = 1'b0;
         timer8_pkg::CS_IO:   tick = 1'b1;
         timer8_pkg::CS_D8:   tick = (presc_r & timer8_pkg::DIV_8) == timer8_pkg::DIV_8;
         timer8_pkg::CS_D64:  tick = (presc_r & timer8_pkg::DIV_64) == timer8_pkg::DIV_64;
         timer8_pkg::CS_D256: tick = (presc_r & timer8_pkg::DIV_256) == timer8_pkg::DIV_256;
         timer8_pkg::CS_D1K:  tick = presc_r == timer8_pkg::DIV_1024;
         timer8_pkg::CS_FALL: tick = ext_fall;
         timer8_pkg::CS_RISE: tick = ext_rise;
      endcase
   end

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   logic at_top, at_bot, at_max, match_a, match_b;
   assign at_top  = timer_count_r == top;
   assign at_bot  = timer_count_r == timer8_pkg::CNT_BOTTOM;
   assign at_max  = timer_count_r == timer8_pkg::CNT_MAX;
   assign match_a = tick && !block_r && timer_count_r == cmp_a_r;
   assign match_b = tick && !block_r && timer_count_r == cmp_b_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_count_r <= timer8_pkg::RESET_VAL;
         dir_down_r    <= 1'b0;
      end else if (wr_cnt) begin
         timer_count_r <= wd;
      end else if (tick) begin
         // dual slope with one tick at TOP
         if (is_pc) begin
            if (at_top)
               dir_down_r <= 1'b1;
            else if (at_bot)
               dir_down_r <= 1'b0;
            if (at_top || (dir_down_r && !at_bot))
               timer_count_r <= timer_count_r - 8'h01;
            else
               timer_count_r <= timer_count_r + 8'h01;
         end else begin
            dir_down_r    <= 1'b0;
            timer_count_r <= at_top ? timer8_pkg::CNT_BOTTOM : timer_count_r + 8'h01;
         end
      end
   end

   // block match on next tick after write
   always_ff @(posedge aclk) begin
      if (!aresetn)
         block_r <= 1'b0;
      else if (wr_cnt)
         block_r <= 1'b1;
      else if (tick)
         block_r <= 1'b0;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_a_buf_r <= timer8_pkg::RESET_VAL;
         cmp_b_buf_r <= timer8_pkg::RESET_VAL;
         cmp_a_r     <= timer8_pkg::RESET_VAL;
         cmp_b_r     <= timer8_pkg::RESET_VAL;
      end else begin
         if (wr_ca)
            cmp_a_buf_r <= wd;
         if (wr_cb)
            cmp_b_buf_r <= wd;
         if (!is_pwm) begin
            cmp_a_r <= wr_ca ? wd : cmp_a_buf_r;
            cmp_b_r <= wr_cb ? wd : cmp_b_buf_r;
         end else if (tick && ((is_pc && at_top) || (is_fast && at_top))) begin
            cmp_a_r <= cmp_a_buf_r;
            cmp_b_r <= cmp_b_buf_r;
         end
      end
   end

   // ------------------------------------------------------------
   // waveform outputs
   // ------------------------------------------------------------
   logic frc_a, frc_b;
   assign frc_a = wr_ctrl_b && wd[timer8_pkg::BIT_FORCE_A] && !is_pwm;
   assign frc_b = wr_ctrl_b && wd[timer8_pkg::BIT_FORCE_B] && !is_pwm;

   function automatic logic next_oc(input logic cur, input logic [1:0] om,
                                    input logic hit, input logic frc,
                                    input logic cmp_top, input logic tgl_ok);
      logic inv;
      logic r;
      inv = om[0];
      r   = cur;
      if (!is_pwm) begin
         if (hit || frc) begin
            unique case (om)
               timer8_pkg::OM_OFF: r = cur;
               timer8_pkg::OM_TGL: r = !cur;
               timer8_pkg::OM_CLR: r = 1'b0;
               timer8_pkg::OM_SET: r = 1'b1;
            endcase
         end
      end else if (om == timer8_pkg::OM_TGL) begin
         // toggle for channel A with upper bit only
         if (tgl_ok && hit)
            r = !cur;
      end else if (om[1]) begin
         if (is_fast) begin
            // fast pwm; top compare acts at bottom only
            if (tick && at_top)
               r = !inv;
            else if (hit && !cmp_top)
               r = inv;
         end else begin
            // phase correct; top compare acts at top
            if (cmp_top) begin
               if (tick && at_top)
                  r = !inv;
            end else if (hit) begin
               r = (dir_down_r || at_top) ? !inv : inv;
            end
         end
      end
      return r;
   endfunction

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         oc_a_r <= 1'b0;
         oc_b_r <= 1'b0;
      end else begin
         oc_a_r <= next_oc(oc_a_r, ctrl_r.out_mode_chan_a, match_a, frc_a,
                           cmp_a_r == top, ctrl_r.waveform_mode_upper);
         oc_b_r <= next_oc(oc_b_r, ctrl_r.out_mode_chan_b, match_b, frc_b,
                           cmp_b_r == top, 1'b0);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pins <= '0;
      end else begin
         pins.wave_out_chan_a <= oc_a_r;
         pins.wave_out_chan_b <= oc_b_r;
         pins.drive_en_chan_a <= (ctrl_r.out_mode_chan_a != timer8_pkg::OM_OFF) && dir_chan_a;
         pins.drive_en_chan_b <= (ctrl_r.out_mode_chan_b != timer8_pkg::OM_OFF) && dir_chan_b;
      end
   end

   // ------------------------------------------------------------
   // flags and interrupt request
   // ------------------------------------------------------------
   logic ovf;
   assign ovf = tick && (is_pc ? at_bot : (wmode == timer8_pkg::WM_FAST_A ? at_top : at_max));

   // flag set; clear by one or vector; set wins
   always_ff @(posedge aclk) begin
      if (!aresetn)
         timer_irq_flags_r <= 3'b000;
      else
         timer_irq_flags_r <= (timer_irq_flags_r & ~(vector_ack | (wr_flags ? wd[2:0] : 3'b000)))
                              | {match_b, match_a, ovf};
   end

   // request gated by mask and global enable
   always_ff @(posedge aclk) begin
      if (!aresetn)
         irq_req <= 3'b000;
      else
         irq_req <= timer_irq_flags_r & timer_irq_mask_r & {3{cpu_status_word_ie}};
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   chk_flag_set_b: assert property (@(posedge aclk) disable iff (!aresetn)
      match_b |=> timer_irq_flags_r[timer8_pkg::BIT_FLAG_B]) else $error("match b flag missing");
   chk_force_noflag: assert property (@(posedge aclk) disable iff (!aresetn)
      (frc_a && !match_a && !timer_irq_flags_r[1] && !vector_ack[1])
      |=> !timer_irq_flags_r[timer8_pkg::BIT_FLAG_A]) else $error("force set a flag");
   chk_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      irq_req[0] |-> $past(timer_irq_mask_r[0] && cpu_status_word_ie)) else $error("irq ungated");
   chk_write_block: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cnt ##1 (tick && !wr_cnt) |-> !match_a && !match_b) else $error("match after write");
   chk_stop_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      (ctrl_r.timer_clk_sel == timer8_pkg::CS_STOP && !wr_cnt) |=> $stable(timer_count_r))
      else $error("stopped counter moved");
   chk_drive_off: assert property (@(posedge aclk) disable iff (!aresetn)
      ctrl_r.out_mode_chan_b == timer8_pkg::OM_OFF |=> !pins.drive_en_chan_b)
      else $error("driver on while off");
   chk_clr_one: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_flags && wd[0] && !ovf) |=> !timer_irq_flags_r[0]) else $error("flag not cleared");
   chk_pc_turn: assert property (@(posedge aclk) disable iff (!aresetn)
      (is_pc && tick && at_top && !wr_cnt && top != timer8_pkg::CNT_BOTTOM) |=> dir_down_r)
      else $error("no turn at top");
endmodule
`default_nettype wire

//--- dv/tb_timer8.sv
// tb_timer8: self-checking bench for the 8-bit timer register block
// assumes: design package and timer8 compiled first; bench drives every port
`timescale 1ns/1ps
`default_nettype none
module tb_timer8;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [4:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic ext = 0, dir_a = 0, dir_b = 0, ie = 0;
   logic [2:0] ack = '0, irq_req;
   timer8_pkg::pins_s pins;
   logic [7:0] exp_q[$];
   logic [7:0] v;
   logic ob = 0;
   int seed = 18150;
   int n_mismatch = 0, num_checks = 0;
   always #5 aclk = ~aclk;
   timer8 timer8_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .ext_count_pin(ext), .dir_chan_a(dir_a),
      .dir_chan_b(dir_b), .cpu_status_word_ie(ie), .vector_ack(ack),
      .pins(pins), .irq_req(irq_req));
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   always @(posedge aclk) begin
      if (rvalid && rready && exp_q.size() > 0) chk(rdata, {24'h0, exp_q.pop_front()});
   end
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
      do @(posedge aclk); while (!(awready && wready));
      awvalid <= 0; wvalid <= 0;
      while (!bvalid) @(posedge aclk);
      chk({30'h0, bresp}, {30'h0, (a > timer8_pkg::ADDR_FLAGS) ?
          timer8_pkg::RESP_SLVERR : timer8_pkg::RESP_OKAY});
      bready <= 0;
      @(posedge aclk);
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      while (!rvalid) @(posedge aclk);
      chk({30'h0, rresp}, {30'h0, (a > timer8_pkg::ADDR_FLAGS) ?
          timer8_pkg::RESP_SLVERR : timer8_pkg::RESP_OKAY});
      rready <= 0;
      @(posedge aclk);
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic pulse(input int n);
      repeat (n) begin
         ext <= 1;
         repeat (4) @(posedge aclk);
         ext <= 0;
         repeat (4) @(posedge aclk);
      end
   endtask
   initial begin
      #200000;
      n_mismatch++;
      summarize;
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      wr(timer8_pkg::ADDR_IRQ, 8'hff);
      for (int i = 0; i < 8; i++) rd(5'(i * 4), 8'h00);
      v = 8'($random(seed));
      wr(timer8_pkg::ADDR_COUNT, v);
      rd(timer8_pkg::ADDR_COUNT, v);
      v = 8'($random(seed));
      wr(timer8_pkg::ADDR_CMP_A, v);
      rd(timer8_pkg::ADDR_CMP_A, v);
      wr(timer8_pkg::ADDR_CTRL_A, 8'hff);
      rd(timer8_pkg::ADDR_CTRL_A, 8'hf3);
      wr(timer8_pkg::ADDR_CTRL_B, 8'h30);
      rd(timer8_pkg::ADDR_CTRL_B, 8'h00);
      wr(timer8_pkg::ADDR_MASK, 8'hf8);
      rd(timer8_pkg::ADDR_MASK, 8'h00);
      wr(timer8_pkg::ADDR_FLAGS, 8'hf8);
      rd(timer8_pkg::ADDR_FLAGS, 8'h00);
      // forced match on both channels in normal mode, each action in turn
      dir_a <= 1;
      dir_b <= 1;
      for (int m = 1; m < 4; m++) begin
         wr(timer8_pkg::ADDR_CTRL_A, 8'((m << 6) | (m << 4)));
         wr(timer8_pkg::ADDR_CTRL_B, 8'hc0);
         repeat (4) @(posedge aclk);
         ob = (m == 1) ? ~ob : (m == 3);
         chk({31'h0, pins.wave_out_chan_b}, {31'h0, ob});
         chk({31'h0, pins.wave_out_chan_a}, {31'h0, ob});
         chk({31'h0, pins.drive_en_chan_b}, 32'h1);
         chk({31'h0, pins.drive_en_chan_a}, 32'h1);
      end
      rd(timer8_pkg::ADDR_CTRL_B, 8'h00);
      rd(timer8_pkg::ADDR_FLAGS, 8'h00);
      // free run through a full count in normal mode
      wr(timer8_pkg::ADDR_CTRL_A, 8'h00);
      wr(timer8_pkg::ADDR_CMP_A, 8'h20);
      wr(timer8_pkg::ADDR_CMP_B, 8'h40);
      wr(timer8_pkg::ADDR_COUNT, 8'h00);
      wr(timer8_pkg::ADDR_CTRL_B, {5'h0, timer8_pkg::CS_IO});
      repeat (300) @(posedge aclk);
      wr(timer8_pkg::ADDR_CTRL_B, 8'h00);
      rd(timer8_pkg::ADDR_FLAGS, 8'h07);
      ie <= 1;
      wr(timer8_pkg::ADDR_MASK, 8'h07);
      repeat (3) @(posedge aclk);
      chk({29'h0, irq_req}, 32'h7);
      wr(timer8_pkg::ADDR_FLAGS, 8'h02);
      rd(timer8_pkg::ADDR_FLAGS, 8'h05);
      ack <= 3'h1;
      @(posedge aclk);
      ack <= 3'h0;
      repeat (2) @(posedge aclk);
      rd(timer8_pkg::ADDR_FLAGS, 8'h04);
      ie <= 0;
      repeat (3) @(posedge aclk);
      chk({29'h0, irq_req}, 32'h0);
      // external pin rising edges, pin direction set as output
      dir_a <= 1;
      wr(timer8_pkg::ADDR_COUNT, 8'h00);
      wr(timer8_pkg::ADDR_CTRL_B, {5'h0, timer8_pkg::CS_RISE});
      pulse(5);
      repeat (6) @(posedge aclk);
      rd(timer8_pkg::ADDR_COUNT, 8'h05);
      // phase-correct then fast pwm on channel B, TOP from compare A, pin-clocked
      wr(timer8_pkg::ADDR_CTRL_A, 8'h20);
      wr(timer8_pkg::ADDR_CMP_A, 8'h04);
      wr(timer8_pkg::ADDR_CMP_B, 8'h02);
      wr(timer8_pkg::ADDR_COUNT, 8'h00);
      wr(timer8_pkg::ADDR_CTRL_A, 8'h21);
      wr(timer8_pkg::ADDR_CTRL_B, 8'h0f);
      pulse(3);
      chk({31'h0, pins.wave_out_chan_b}, 32'h0);
      pulse(4);
      chk({31'h0, pins.wave_out_chan_b}, 32'h1);
      rd(timer8_pkg::ADDR_COUNT, 8'h01);
      wr(timer8_pkg::ADDR_CTRL_A, 8'h23);
      pulse(2);
      chk({31'h0, pins.wave_out_chan_b}, 32'h0);
      pulse(2);
      chk({31'h0, pins.wave_out_chan_b}, 32'h1);
      rd(timer8_pkg::ADDR_COUNT, 8'h00);
      summarize;
   end
endmodule
`default_nettype wire
